// >>> hw/speech_envelope_integrator.sv
// Purpose: per-channel speech level integrator, two-pole recursive low-pass
// Assumes: one sample per channel per 8 kHz tick, offered with valid/ready
// Notes: one shared MAC, five cycles per sample; coefficients loadable at any time
// Notes on behaviour
// [RULE1] each channel level comes from a two-pole recursive filter on magnitudes
// [RULE2] four multiply-accumulates per update, two state words per channel
// [RULE3] feedback and feedforward paths share one pair of delay words
// [RULE4] leading numerator term taken as one, its gain dropped
// [RULE5] default coefficients -1.9945, 0.9945, 2 and 1
// [RULE6] defaults give a 5 Hz low-pass corner at 8 kHz update rate
// [RULE7] output is a slow level with speech envelopes smoothed away
// [RULE8] coefficients are loadable, not fixed
// [RULE9] each input is multiplied by its channel scale factor first
// [RULE10] four coefficients read in wrapping order, modulo four, each update
// [RULE11] coefficients stored halved; products doubled so range spans plus/minus two
// [RULE12] two delay words stored per channel between samples
// [RULE13] w = x - a1*w1 - a2*w2; y = w + b1*w1 + b2*w2; then shift delays
// [RULE14] saturating arithmetic, rounding on last accumulate, state cleared on reset
`timescale 1ns/1ps
`default_nettype none

module speech_envelope_integrator (
  input wire logic clk,
  input wire logic reset,
  input wire envelope_pkg::sample_s sample_in,
  output logic in_ready,
  input wire envelope_pkg::coef_write_s coef_wr,
  input wire envelope_pkg::scale_write_s scale_wr,
  output envelope_pkg::level_s level_out
);
  typedef struct packed {
    envelope_pkg::phase_e phase;
    logic [envelope_pkg::COEF_IDX_W-1:0] coef_ptr;
    logic [envelope_pkg::CHAN_W-1:0] chan;
    logic signed [envelope_pkg::ACC_W-1:0] acc;
    envelope_pkg::word_t w_new;
    envelope_pkg::word_t [envelope_pkg::COEF_COUNT-1:0] coef;
    envelope_pkg::word_t [envelope_pkg::CHANNELS-1:0] scale;
    envelope_pkg::word_t [envelope_pkg::CHANNELS-1:0] w1;
    envelope_pkg::word_t [envelope_pkg::CHANNELS-1:0] w2;
    logic in_ready;
    envelope_pkg::level_s level;
  } engine_state_s;

  engine_state_s st;
  engine_state_s next_st;

  logic signed [envelope_pkg::ACC_W-1:0] mac_acc;
  logic signed [envelope_pkg::DATA_W-1:0] mac_a;
  logic signed [envelope_pkg::DATA_W-1:0] mac_b;
  logic signed [envelope_pkg::DATA_W-1:0] mac_sat;
  logic mac_clear;
  logic mac_negate;
  logic mac_rnd;
  logic accept;

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  // absolute value, most negative clipped to full scale
  function automatic envelope_pkg::word_t magnitude(input envelope_pkg::word_t v);
    if (v == envelope_pkg::WORD_MIN) begin
      return envelope_pkg::WORD_MAX;
    end
    return v[envelope_pkg::DATA_W-1] ? -v : v;
  endfunction

  // place a data word at the accumulator's binary point
  function automatic logic signed [envelope_pkg::ACC_W-1:0] widen(input envelope_pkg::word_t v);
    return envelope_pkg::ACC_W'(v) <<< envelope_pkg::FRAC_W;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // shared MAC operand selection

  assign accept = (st.phase == envelope_pkg::PH_IDLE) && sample_in.valid;

  always_comb begin
    mac_clear = 1'b0;
    mac_negate = 1'b0;
    mac_rnd = 1'b0;
    mac_b = st.coef[st.coef_ptr]; // RULE10
    mac_a = st.w2[st.chan];
    unique case (st.phase)
      envelope_pkg::PH_IDLE: begin
        mac_a = magnitude(sample_in.sample);
        mac_b = st.scale[sample_in.chan]; // RULE9
        mac_clear = 1'b1;
      end
      envelope_pkg::PH_FB1: begin
        mac_a = st.w1[st.chan];
        mac_negate = 1'b1; // RULE13
      end
      envelope_pkg::PH_FB2: begin
        mac_negate = 1'b1; // RULE13
      end
      envelope_pkg::PH_FF1: begin
        mac_a = st.w1[st.chan];
      end
      envelope_pkg::PH_FF2: begin
        mac_rnd = 1'b1; // RULE14
      end
    endcase
  end

  sat_mac u_mac (
    .acc(st.acc),
    .mul_a(mac_a),
    .mul_b(mac_b),
    .clear(mac_clear),
    .negate(mac_negate),
    .dbl(st.phase != envelope_pkg::PH_IDLE),
    .rnd(mac_rnd),
    .acc_out(mac_acc),
    .sat(mac_sat)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer and storage

  always_comb begin
    next_st = st;
    next_st.level.valid = 1'b0;
    if (coef_wr.valid) begin
      next_st.coef[coef_wr.index] = coef_wr.value; // RULE8
    end
    if (scale_wr.valid) begin
      next_st.scale[scale_wr.chan] = scale_wr.value; // RULE9
    end
    unique case (st.phase)
      envelope_pkg::PH_IDLE: begin
        if (sample_in.valid) begin
          next_st.chan = sample_in.chan;
          next_st.acc = mac_acc; // RULE9
          next_st.phase = envelope_pkg::PH_FB1;
        end
      end
      envelope_pkg::PH_FB1: begin
        next_st.acc = mac_acc; // RULE1
        next_st.coef_ptr = st.coef_ptr + 2'h1; // RULE10
        next_st.phase = envelope_pkg::PH_FB2;
      end
      envelope_pkg::PH_FB2: begin
        // w saturated before it is stored and reused
        next_st.w_new = mac_sat; // RULE13
        // leading numerator term is unity: y starts from w itself
        next_st.acc = widen(mac_sat); // RULE4 RULE3
        next_st.coef_ptr = st.coef_ptr + 2'h1; // RULE10
        next_st.phase = envelope_pkg::PH_FF1;
      end
      envelope_pkg::PH_FF1: begin
        next_st.acc = mac_acc; // RULE13
        next_st.coef_ptr = st.coef_ptr + 2'h1; // RULE10
        next_st.phase = envelope_pkg::PH_FF2;
      end
      envelope_pkg::PH_FF2: begin
        next_st.acc = mac_acc;
        next_st.coef_ptr = st.coef_ptr + 2'h1; // RULE10
        next_st.level.valid = 1'b1; // RULE7
        next_st.level.chan = st.chan;
        next_st.level.level = mac_sat; // RULE7
        next_st.w2[st.chan] = st.w1[st.chan]; // RULE12 RULE3
        next_st.w1[st.chan] = st.w_new; // RULE12 RULE2
        next_st.phase = envelope_pkg::PH_IDLE;
      end
    endcase
    next_st.in_ready = (next_st.phase == envelope_pkg::PH_IDLE);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st <= '0; // RULE14
      st.coef <= envelope_pkg::COEF_INIT; // RULE5
      st.scale <= {envelope_pkg::CHANNELS{envelope_pkg::SCALE_INIT}};
      st.in_ready <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign in_ready = st.in_ready;
  assign level_out = st.level;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence s_feedback;
    st.phase == envelope_pkg::PH_FB1 ##1 st.phase == envelope_pkg::PH_FB2;
  endsequence

  sequence s_feedforward;
    st.phase == envelope_pkg::PH_FF1 ##1 st.phase == envelope_pkg::PH_FF2;
  endsequence

  a_four_macs: assert property (accept |=> s_feedback ##1 s_feedforward ##1 level_out.valid) // RULE2
    else $error("update did not take four MAC steps");

  a_ptr_start: assert property (accept |-> st.coef_ptr == envelope_pkg::IDX_FEEDBACK_FIRST) // RULE10
    else $error("coefficient pointer not at first slot on accept");

  a_ptr_wrap: assert property (st.phase == envelope_pkg::PH_FF2 |-> ##1 st.coef_ptr
    == envelope_pkg::IDX_FEEDBACK_FIRST && $past(st.coef_ptr) == envelope_pkg::IDX_FEEDFORWARD_SECOND) // RULE10
    else $error("coefficient pointer did not wrap");

  a_delay_shift: assert property (st.phase == envelope_pkg::PH_FF2 |=>
    st.w2[$past(st.chan)] == $past(st.w1[st.chan]) && st.w1[$past(st.chan)] == $past(st.w_new)) // RULE12
    else $error("delay words not shifted");

  a_busy_refuse: assert property (accept |=> !in_ready [*4] ##1 in_ready) // RULE2
    else $error("ready not low for exactly four cycles");

  a_channel_kept: assert property (accept |-> ##5 level_out.valid && level_out.chan
    == $past(sample_in.chan, 5)) // RULE9
    else $error("level reported for wrong channel");

  a_coef_load: assert property (coef_wr.valid |=> st.coef[$past(coef_wr.index)]
    == $past(coef_wr.value)) // RULE8
    else $error("coefficient write lost");

  a_round_final: assert property (mac_rnd |-> st.phase == envelope_pkg::PH_FF2 ##1 level_out.valid) // RULE14
    else $error("rounding outside final accumulate");

  a_reset_clear: assert property (@(posedge clk) disable iff (1'b0) reset |=> st.w1 == '0
    && st.w2 == '0 && !level_out.valid && in_ready) // RULE14
    else $error("state not cleared by reset");
endmodule // speech_envelope_integrator

`default_nettype wire

// >>> hw/envelope_pkg.sv
// Purpose: shared types and constants for the speech envelope integrator, plus its MAC unit
// Assumes: 24-bit two's complement fractional data, 56-bit accumulator
// Notes: coefficients are stored pre-halved; the MAC doubles their products
`default_nettype none

package envelope_pkg;
  localparam int unsigned DATA_W = 24;
  localparam int unsigned ACC_W = 56;
  localparam int unsigned FRAC_W = 23;
  localparam int unsigned CHANNELS = 8;
  localparam int unsigned CHAN_W = 3;
  localparam int unsigned COEF_COUNT = 4;
  localparam int unsigned COEF_IDX_W = 2;

  typedef logic signed [DATA_W-1:0] word_t;

  // coefficient slots, in update order
  localparam logic [COEF_IDX_W-1:0] IDX_FEEDBACK_FIRST = 2'h0;
  localparam logic [COEF_IDX_W-1:0] IDX_FEEDBACK_SECOND = 2'h1;
  localparam logic [COEF_IDX_W-1:0] IDX_FEEDFORWARD_FIRST = 2'h2;
  localparam logic [COEF_IDX_W-1:0] IDX_FEEDFORWARD_SECOND = 2'h3;

  // halved defaults: -1.9945/2, 0.9945/2, 2/2 (clipped), 1/2 - 5 Hz corner at 8 kHz
  localparam word_t FEEDBACK_COEF_FIRST_INIT = 24'h805A1D; // RULE5 RULE6 RULE11
  localparam word_t FEEDBACK_COEF_SECOND_INIT = 24'h3FA5E3; // RULE5 RULE11
  localparam word_t FEEDFORWARD_COEF_FIRST_INIT = 24'h7FFFFF; // RULE5 RULE11
  localparam word_t FEEDFORWARD_COEF_SECOND_INIT = 24'h400000; // RULE5 RULE11
  localparam word_t [COEF_COUNT-1:0] COEF_INIT = {FEEDFORWARD_COEF_SECOND_INIT,
    FEEDFORWARD_COEF_FIRST_INIT, FEEDBACK_COEF_SECOND_INIT, FEEDBACK_COEF_FIRST_INIT};
  localparam word_t SCALE_INIT = 24'h010000;
  localparam word_t WORD_MAX = 24'h7FFFFF;
  localparam word_t WORD_MIN = 24'h800000;

  localparam logic signed [ACC_W-1:0] ACC_WORD_MAX = 56'sh000000007FFFFF;
  localparam logic signed [ACC_W-1:0] ACC_WORD_MIN = 56'shFFFFFFFF800000;
  localparam logic signed [ACC_W-1:0] ROUND_HALF = 56'sh00000000400000;

  typedef enum logic [2:0] {PH_IDLE, PH_FB1, PH_FB2, PH_FF1, PH_FF2} phase_e;

  typedef struct packed {
    logic valid;
    logic [CHAN_W-1:0] chan;
    word_t sample;
  } sample_s;

  typedef struct packed {
    logic valid;
    logic [COEF_IDX_W-1:0] index;
    word_t value;
  } coef_write_s;

  typedef struct packed {
    logic valid;
    logic [CHAN_W-1:0] chan;
    word_t value;
  } scale_write_s;

  typedef struct packed {
    logic valid;
    logic [CHAN_W-1:0] chan;
    word_t level;
  } level_s;
endpackage

`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// saturating multiply-accumulate, combinational
module sat_mac (
  input wire logic signed [envelope_pkg::ACC_W-1:0] acc,
  input wire logic signed [envelope_pkg::DATA_W-1:0] mul_a,
  input wire logic signed [envelope_pkg::DATA_W-1:0] mul_b,
  input wire logic clear,
  input wire logic negate,
  input wire logic dbl,
  input wire logic rnd,
  output logic signed [envelope_pkg::ACC_W-1:0] acc_out,
  output logic signed [envelope_pkg::DATA_W-1:0] sat
);
  logic signed [2*envelope_pkg::DATA_W-1:0] prod;
  logic signed [envelope_pkg::ACC_W-1:0] term;
  logic signed [envelope_pkg::ACC_W-1:0] sum;
  logic signed [envelope_pkg::ACC_W-1:0] shifted;

  always_comb begin
    prod = mul_a * mul_b;
    term = envelope_pkg::ACC_W'(prod);
    if (dbl) begin
      term = term <<< 1; // RULE11
    end
    if (negate) begin
      term = -term;
    end
    sum = (clear ? '0 : acc) + term;
    if (rnd) begin
      sum = sum + envelope_pkg::ROUND_HALF; // RULE14
    end
    acc_out = sum;
    shifted = sum >>> envelope_pkg::FRAC_W;
    if (shifted > envelope_pkg::ACC_WORD_MAX) begin
      sat = envelope_pkg::WORD_MAX; // RULE14
    end else if (shifted < envelope_pkg::ACC_WORD_MIN) begin
      sat = envelope_pkg::WORD_MIN; // RULE14
    end else begin
      sat = shifted[envelope_pkg::DATA_W-1:0];
    end
  end
endmodule // sat_mac

`default_nettype wire

// >>> dv/envelope_source.sv
// Purpose: upstream converter stand-in that offers channel samples
// Assumes: a sample is held until an edge sees in_ready high
// Notes: a released sample field shows inverted data
`timescale 1ns/1ps
`default_nettype none

module envelope_source (
  input wire logic clk,
  input wire logic in_ready,
  output var envelope_pkg::sample_s sample_in
);
  initial sample_in = '0;

  task automatic offer(input int ch, input envelope_pkg::word_t x, input int gap);
    if (gap > 0) begin
      repeat (gap) @(posedge clk);
      #1;
    end
    sample_in = {1'b1, ch[2:0], x};
    while (in_ready !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1;
    sample_in = {1'b0, sample_in.chan, ~x};
  endtask
endmodule // envelope_source

`default_nettype wire

// >>> dv/speech_envelope_integrator_tb.sv
// Purpose: self-checking bench for the speech envelope integrator
// Assumes: bit-exact integer model of the five-step update
// Notes: samples offered while busy must be ignored
`timescale 1ns/1ps
`default_nettype none

module speech_envelope_integrator_tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  envelope_pkg::sample_s sample_in;
  logic in_ready;
  envelope_pkg::coef_write_s coef_wr = '0;
  envelope_pkg::scale_write_s scale_wr = '0;
  envelope_pkg::level_s level_out;
  int errors = 0;
  int comparisons = 0;
  int pulses = 0;
  int results = 0;
  longint w1[8], w2[8], coef[4], scale[8];

  always #2.5 clk = ~clk;
  always @(negedge clk) if (level_out.valid === 1'b1) pulses++;

  envelope_source i_envelope_source (.clk(clk), .in_ready(in_ready), .sample_in(sample_in));
  speech_envelope_integrator i_speech_envelope_integrator (.clk(clk), .reset(reset),
    .sample_in(sample_in), .in_ready(in_ready), .coef_wr(coef_wr), .scale_wr(scale_wr),
    .level_out(level_out));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [28:0] exp, input logic [28:0] got);
    comparisons++;
    if (exp !== got) begin
      errors++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  function automatic longint sat(input longint v);
    return v > 8388607 ? 8388607 : (v < -8388608 ? -8388608 : v);
  endfunction

  task automatic model_init();
    for (int i = 0; i < 8; i++) begin
      w1[i] = 0;
      w2[i] = 0;
      scale[i] = longint'(envelope_pkg::SCALE_INIT);
    end
    for (int i = 0; i < 4; i++) coef[i] = longint'(envelope_pkg::word_t'(envelope_pkg::COEF_INIT[i]));
  endtask

  // one update through the model, then the handshake and its fixed latency
  task automatic run(input int ch, input envelope_pkg::word_t x, input int gap);
    longint m, acc, w, y;
    m = x < 0 ? -longint'(x) : longint'(x);
    if (m > 8388607) m = 8388607;
    acc = m * scale[ch] - 2 * coef[0] * w1[ch] - 2 * coef[1] * w2[ch];
    w = sat(acc >>> 23);
    // y is built on the stored, saturated w, not on the wide sum
    acc = (w <<< 23) + 2 * coef[2] * w1[ch] + 2 * coef[3] * w2[ch];
    y = sat((acc + 4194304) >>> 23);
    w2[ch] = w1[ch];
    w1[ch] = w;
    results++;
    i_envelope_source.offer(ch, x, gap);
    for (int n = 1; n < 5; n++) begin
      check({2'b00, 27'h0}, {in_ready, level_out.valid, 27'h0});
      if (n == 2) i_envelope_source.sample_in = {1'b1, ch[2:0] ^ 3'h1, 24'($urandom)};
      if (n == 4) i_envelope_source.sample_in.valid = 1'b0;
      @(posedge clk);
      #1;
    end
    check({2'b11, ch[2:0], y[23:0]}, {in_ready, level_out});
  endtask

  task automatic load(input bit is_coef, input int idx, input envelope_pkg::word_t v);
    @(posedge clk);
    #1;
    if (is_coef) begin
      coef_wr = {1'b1, idx[1:0], v};
      coef[idx] = longint'(v);
    end else begin
      scale_wr = {1'b1, idx[2:0], v};
      scale[idx] = longint'(v);
    end
    @(posedge clk);
    #1;
    coef_wr.valid = 1'b0;
    scale_wr.valid = 1'b0;
  endtask

  task automatic burst(input int count);
    for (int i = 0; i < count; i++) run($urandom % 8, 24'($urandom), $urandom % 3);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(97527));
    model_init();
    repeat (3) @(posedge clk);
    #1;
    reset = 1'b0;
    for (int i = 0; i < 24; i++) run(0, 24'h400000, 0);
    burst(160);
    run(5, envelope_pkg::WORD_MIN, 1);
    for (int i = 0; i < 8; i++) load(1'b0, i, 24'($urandom % 32'h100000));
    for (int i = 0; i < 4; i++) load(1'b1, i, 24'($urandom % 32'h200000));
    burst(80);
    for (int i = 0; i < 4; i++) load(1'b1, i, 24'($urandom));
    burst(40);
    @(posedge clk);
    #1;
    reset = 1'b1;
    @(posedge clk);
    #1;
    check({1'b1, 28'h0}, {in_ready, level_out});
    reset = 1'b0;
    model_init();
    burst(40);
    @(posedge clk);
    #1;
    check(29'(results), 29'(pulses));
    report_and_stop();
  end

  initial begin
    #200000;
    errors++;
    report_and_stop();
  end
endmodule // speech_envelope_integrator_tb

`default_nettype wire
